// *** hw/xxb_bridge.sv ***
`timescale 1ns/1ps
`default_nettype none
module xxb_bridge
  import xxb_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clocks and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_lnk_clk,
  // XGMII transmit input
  input wire logic [31:0] i_xgmii_tx_data,
  input wire logic [3:0] i_xgmii_tx_ctrl,
  // XGMII receive output
  output logic [31:0] o_xgmii_rx_data,
  output logic [3:0] o_xgmii_rx_ctrl,
  output logic o_xgmii_rx_clk,
  // XAUI side, deskewed symbols with K flags
  input wire logic [31:0] i_xaui_rx_data,
  input wire logic [3:0] i_xaui_rx_k,
  output logic [31:0] o_xaui_tx_data,
  output logic [3:0] o_xaui_tx_k,
  // Overflow status
  output logic o_tx_ovf,
  output logic o_rx_ovf
);
  localparam int AW = $clog2(DEPTH);

  xxb_strm_if #(.W(WORDW)) tx_wr ();
  xxb_strm_if #(.W(WORDW)) tx_rd ();
  xxb_strm_if #(.W(WORDW)) rx_wr ();
  xxb_strm_if #(.W(WORDW)) rx_rd ();

  logic lnk_rst;
  logic [AW:0] tx_wlvl, tx_rlvl, rx_wlvl, rx_rlvl;

  // Reset reaches the link domain through a synchroniser
  xxb_sync #(.W(1)) u_rst_sync (.i_clk(i_lnk_clk), .i_d(i_sys_rst), .o_q(lnk_rst));

  // ---------------------------------------------------------------------------
  // Transmit: DDR capture and write into slip buffer
  // ---------------------------------------------------------------------------
  logic [COLW-1:0] rise_q, fall_q;
  logic [WORDW-1:0] tx_w_q;
  logic rs_vld_q, tw_vld_q, tx_del;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      rise_q <= IDLE_COL;
    end else begin
      rise_q <= {i_xgmii_tx_ctrl, i_xgmii_tx_data};
    end
  end

  always_ff @(negedge i_ref_clk) begin
    if (i_sys_rst) begin
      fall_q <= IDLE_COL;
    end else begin
      fall_q <= {i_xgmii_tx_ctrl, i_xgmii_tx_data};
    end
  end

  // Rising-edge column is the earlier one and sits in the low half
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      tx_w_q <= {IDLE_COL, IDLE_COL};
      rs_vld_q <= 1'b0;
      tw_vld_q <= 1'b0;
    end else begin
      tx_w_q <= {fall_q, rise_q};
      rs_vld_q <= 1'b1;
      tw_vld_q <= rs_vld_q;
    end
  end

  // Only all-idle words are dropped, so frames are never cut
  assign tx_del = col_idle(tx_w_q[35:0]) && col_idle(tx_w_q[71:36]) &&
                  (tx_wlvl >= (AW+1)'(WM_HIGH) || !tx_wr.ready);
  assign tx_wr.valid = tw_vld_q && !tx_del;
  assign tx_wr.data = tx_w_q;

  // Data arriving against a full buffer cannot be held off on XGMII
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) o_tx_ovf <= 1'b0;
    else o_tx_ovf <= tx_wr.valid && !tx_wr.ready;
  end

  xxb_fifo #(.W(WORDW), .DEPTH(DEPTH)) u_tx_fifo (
    .i_wr_clk(i_ref_clk), .i_wr_rst(i_sys_rst), .s_wr(tx_wr), .o_wr_lvl(tx_wlvl),
    .i_rd_clk(i_lnk_clk), .i_rd_rst(lnk_rst), .s_rd(tx_rd), .o_rd_lvl(tx_rlvl)
  );

  // ---------------------------------------------------------------------------
  // Transmit: slip read, idle generation and encoding (link clock)
  // ---------------------------------------------------------------------------
  xxb_slip_e tx_st_q;
  logic [WORDW-1:0] tx_cur_q;
  logic [COLW-1:0] tx_col;
  logic tx_half_q, tx_frm_q, tx_run;
  logic [4:0] a_cnt_q;
  logic [6:0] lfsr_q;
  logic [35:0] tx_enc;

  assign tx_run = tx_st_q == SL_RUN;
  assign tx_rd.ready = tx_run && !tx_half_q;
  assign tx_col = tx_half_q ? tx_cur_q[35:0] : tx_cur_q[71:36];

  always_ff @(posedge i_lnk_clk) begin
    if (lnk_rst) begin
      tx_st_q <= SL_FILL;
    end else if (!tx_run && tx_rlvl >= (AW+1)'(WM_START)) begin
      tx_st_q <= SL_RUN;
    end
  end

  // Empty buffer between frames inserts idles; inside a frame it is an error
  always_ff @(posedge i_lnk_clk) begin
    if (lnk_rst) begin
      tx_cur_q <= {IDLE_COL, IDLE_COL};
      tx_half_q <= 1'b0;
    end else if (tx_run) begin
      tx_half_q <= !tx_half_q;
      if (!tx_half_q) begin
        if (tx_rd.valid) tx_cur_q <= tx_rd.data;
        else tx_cur_q <= tx_frm_q ? {ERR_COL, ERR_COL} : {IDLE_COL, IDLE_COL};
      end
    end
  end

  always_ff @(posedge i_lnk_clk) begin
    if (lnk_rst) tx_frm_q <= 1'b0;
    else if (tx_run) tx_frm_q <= frm_next(tx_frm_q, tx_col);
  end

  always_ff @(posedge i_lnk_clk) begin
    if (lnk_rst) lfsr_q <= LFSR_SEED;
    else lfsr_q <= {lfsr_q[5:0], lfsr_q[6] ^ lfsr_q[5]};
  end

  // Align spacing is random in 16..31 idle columns
  always_ff @(posedge i_lnk_clk) begin
    if (lnk_rst) begin
      a_cnt_q <= ALIGN_MIN;
    end else if (!tx_run || col_idle(tx_col)) begin
      if (a_cnt_q == '0) a_cnt_q <= ALIGN_MIN | {1'b0, lfsr_q[3:0]};
      else a_cnt_q <= a_cnt_q - 1'b1;
    end
  end

  for (genvar l = 0; l < LANES; l++) begin : g_enc
    assign tx_enc[9*l+:9] = enc_sym(tx_col[8*l+:8], tx_col[32+l], l);
  end

  always_ff @(posedge i_lnk_clk) begin
    if (lnk_rst) begin
      o_xaui_tx_data <= {4{KC_SYNC}};
      o_xaui_tx_k <= 4'hf;
    end else if (!tx_run || col_idle(tx_col)) begin
      o_xaui_tx_k <= 4'hf;
      if (a_cnt_q == '0) o_xaui_tx_data <= {4{KC_ALIGN}};
      else o_xaui_tx_data <= {4{lfsr_q[0] ? KC_SYNC : KC_SKIP}};
    end else begin
      for (int l = 0; l < LANES; l++) begin
        o_xaui_tx_k[l] <= tx_enc[9*l+8];
        o_xaui_tx_data[8*l+:8] <= tx_enc[9*l+:8];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Receive: decode and write into slip buffer (link clock)
  // ---------------------------------------------------------------------------
  logic [COLW-1:0] rx_dec, rx_lo_q;
  logic rx_ph_q, rx_del;

  // Lanes arrive already deskewed by the transceiver
  for (genvar l = 0; l < LANES; l++) begin : g_dec
    logic [8:0] sym;
    assign sym = dec_sym(i_xaui_rx_data[8*l+:8], i_xaui_rx_k[l], l);
    assign rx_dec[8*l+:8] = sym[7:0];
    assign rx_dec[32+l] = sym[8];
  end

  always_ff @(posedge i_lnk_clk) begin
    if (lnk_rst) begin
      rx_lo_q <= IDLE_COL;
      rx_ph_q <= 1'b0;
    end else begin
      rx_ph_q <= !rx_ph_q;
      if (!rx_ph_q) rx_lo_q <= rx_dec;
    end
  end

  assign rx_del = col_idle(rx_lo_q) && col_idle(rx_dec) &&
                  (rx_wlvl >= (AW+1)'(WM_HIGH) || !rx_wr.ready);
  assign rx_wr.valid = rx_ph_q && !rx_del;
  assign rx_wr.data = {rx_dec, rx_lo_q};

  always_ff @(posedge i_lnk_clk) begin
    if (lnk_rst) o_rx_ovf <= 1'b0;
    else o_rx_ovf <= rx_wr.valid && !rx_wr.ready;
  end

  xxb_fifo #(.W(WORDW), .DEPTH(DEPTH)) u_rx_fifo (
    .i_wr_clk(i_lnk_clk), .i_wr_rst(lnk_rst), .s_wr(rx_wr), .o_wr_lvl(rx_wlvl),
    .i_rd_clk(i_ref_clk), .i_rd_rst(i_sys_rst), .s_rd(rx_rd), .o_rd_lvl(rx_rlvl)
  );

  // ---------------------------------------------------------------------------
  // Receive: slip read and DDR output
  // ---------------------------------------------------------------------------
  xxb_slip_e rx_st_q;
  logic [COLW-1:0] rx_c0_q, rx_c1_q, rx_c1n_q;
  logic rx_frm_q, rx_run;

  assign rx_run = rx_st_q == SL_RUN;
  assign rx_rd.ready = rx_run;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      rx_st_q <= SL_FILL;
    end else if (!rx_run && rx_rlvl >= (AW+1)'(WM_START)) begin
      rx_st_q <= SL_RUN;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      rx_c0_q <= IDLE_COL;
      rx_c1_q <= IDLE_COL;
    end else if (rx_run && rx_rd.valid) begin
      rx_c0_q <= rx_rd.data[35:0];
      rx_c1_q <= rx_rd.data[71:36];
    end else if (rx_run && rx_frm_q) begin
      rx_c0_q <= ERR_COL;
      rx_c1_q <= ERR_COL;
    end else begin
      rx_c0_q <= IDLE_COL;
      rx_c1_q <= IDLE_COL;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) rx_frm_q <= 1'b0;
    else rx_frm_q <= frm_next(frm_next(rx_frm_q, rx_c0_q), rx_c1_q);
  end

  // Second column is re-timed on the falling edge so the mux never glitches
  always_ff @(negedge i_ref_clk) begin
    if (i_sys_rst) rx_c1n_q <= IDLE_COL;
    else rx_c1n_q <= rx_c1_q;
  end

  assign o_xgmii_rx_data = i_ref_clk ? rx_c0_q[31:0] : rx_c1n_q[31:0];
  assign o_xgmii_rx_ctrl = i_ref_clk ? rx_c0_q[35:32] : rx_c1n_q[35:32];
  assign o_xgmii_rx_clk = i_ref_clk;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb_ref @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  AST_RX_FILL_IDLE: assert property (!rx_run |=> rx_c0_q == IDLE_COL && rx_c1_q == IDLE_COL)
    else $error("receive output not idle while filling");

  AST_RX_START: assert property (!rx_run && rx_rlvl >= (AW+1)'(WM_START) |=> rx_run)
    else $error("receive slip did not start at watermark");

  AST_RX_PASS: assert property (rx_rd.valid && rx_rd.ready
    |=> {rx_c1_q, rx_c0_q} == $past(rx_rd.data))
    else $error("receive word not passed to XGMII");

  AST_RX_INSERT: assert property (rx_run && !rx_rd.valid && !rx_frm_q
    |=> rx_c0_q == IDLE_COL && rx_c1_q == IDLE_COL)
    else $error("receive underrun between frames did not insert idle");

  AST_TX_KEEP_DATA: assert property (tw_vld_q && !col_idle(tx_w_q[35:0]) |-> tx_wr.valid)
    else $error("transmit frame word was deleted");

  AST_TX_DDR: assert property (tw_vld_q
    |-> tx_w_q[35:0] == {$past(i_xgmii_tx_ctrl, 2), $past(i_xgmii_tx_data, 2)})
    else $error("rising column not captured into transmit word");

  AST_TX_IDLEGEN: assert property (@(posedge i_lnk_clk) disable iff (lnk_rst)
    tx_run && col_idle(tx_col) |=> o_xaui_tx_k == 4'hf &&
    o_xaui_tx_data[15:0] == {2{o_xaui_tx_data[7:0]}})
    else $error("idle column not sent as matching code groups");

  AST_TX_ALIGN: assert property (@(posedge i_lnk_clk) disable iff (lnk_rst)
    a_cnt_q == '0 && (!tx_run || col_idle(tx_col)) |=> o_xaui_tx_data == {4{KC_ALIGN}})
    else $error("align group missing when spacing count expired");

  AST_TX_LANE0: assert property (@(posedge i_lnk_clk) disable iff (lnk_rst)
    tx_run && tx_col[33] && tx_col[15:8] == XG_START && !col_idle(tx_col)
    |=> o_xaui_tx_data[15:8] == XG_ERR && o_xaui_tx_k[1])
    else $error("start on lane one not turned into error");

  AST_RX_LANE: assert property (@(posedge i_lnk_clk) disable iff (lnk_rst)
    !rx_ph_q && i_xaui_rx_k[1] && i_xaui_rx_data[15:8] == KC_SKIP
    |=> rx_lo_q[15:8] == XG_IDLE && rx_lo_q[33])
    else $error("skip on lane one not decoded to idle on lane one");

  COV_RX_RUN: cover property (!rx_run ##1 rx_run);
  COV_RX_FRAME: cover property (rx_run && !rx_frm_q ##1 rx_frm_q);
  COV_TX_ALIGN: cover property (@(posedge i_lnk_clk) o_xaui_tx_data == {4{KC_ALIGN}});
  COV_TX_START: cover property (@(posedge i_lnk_clk) !tx_frm_q ##1 tx_frm_q);
endmodule
`default_nettype wire

// *** hw/xxb_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module xxb_fifo #(
  parameter int W = 72,
  parameter int DEPTH = 16,
  localparam int AW = $clog2(DEPTH)
) (
  // Write side
  input wire logic i_wr_clk,
  input wire logic i_wr_rst,
  xxb_strm_if.snk s_wr,
  output logic [AW:0] o_wr_lvl,
  // Read side
  input wire logic i_rd_clk,
  input wire logic i_rd_rst,
  xxb_strm_if.src s_rd,
  output logic [AW:0] o_rd_lvl
);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0] wb_q, rb_q, wg_q, rg_q, wg_s, rg_s, wnx, rnx;

  function automatic logic [AW:0] g2b(input logic [AW:0] g);
    logic [AW:0] b;
    b[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--) b[i] = b[i+1] ^ g[i];
    return b;
  endfunction

  assign wnx = wb_q + 1'b1;
  assign rnx = rb_q + 1'b1;
  // Level seen from each side is pessimistic by the synchroniser delay
  assign o_wr_lvl = wb_q - g2b(rg_s);
  assign o_rd_lvl = g2b(wg_s) - rb_q;
  assign s_wr.ready = o_wr_lvl != (AW+1)'(DEPTH);
  assign s_rd.valid = o_rd_lvl != '0;
  assign s_rd.data = mem_q[rb_q[AW-1:0]];

  always_ff @(posedge i_wr_clk) begin
    if (i_wr_rst) begin
      wb_q <= '0;
      wg_q <= '0;
    end else if (s_wr.valid && s_wr.ready) begin
      wb_q <= wnx;
      wg_q <= wnx ^ (wnx >> 1);
    end
  end

  always_ff @(posedge i_wr_clk) begin
    if (s_wr.valid && s_wr.ready) mem_q[wb_q[AW-1:0]] <= s_wr.data;
  end

  always_ff @(posedge i_rd_clk) begin
    if (i_rd_rst) begin
      rb_q <= '0;
      rg_q <= '0;
    end else if (s_rd.valid && s_rd.ready) begin
      rb_q <= rnx;
      rg_q <= rnx ^ (rnx >> 1);
    end
  end

  xxb_sync #(.W(AW + 1)) u_wsync (.i_clk(i_rd_clk), .i_d(wg_q), .o_q(wg_s));
  xxb_sync #(.W(AW + 1)) u_rsync (.i_clk(i_wr_clk), .i_d(rg_q), .o_q(rg_s));
endmodule
`default_nettype wire

// *** hw/xxb_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module xxb_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge i_clk) begin
    meta_q <= i_d;
    o_q <= meta_q;
  end
endmodule
`default_nettype wire

// *** include/xxb_pkg.sv ***
package xxb_pkg;
  // ---------------------------------------------------------------------------
  // Geometry and rates
  // ---------------------------------------------------------------------------
  localparam int LANES = 4;
  localparam int COLW = 36;
  localparam int WORDW = 72;
  localparam int FIFO_DEPTH = 16;
  localparam real XGMII_CLK_MHZ = 156.25;
  localparam real LANE_GBPS = 3.125;
  // ---------------------------------------------------------------------------
  // Control octets and code groups
  // ---------------------------------------------------------------------------
  localparam logic [7:0] XG_IDLE = 8'h07;
  localparam logic [7:0] XG_START = 8'hfb;
  localparam logic [7:0] XG_TERM = 8'hfd;
  localparam logic [7:0] XG_ERR = 8'hfe;
  localparam logic [7:0] XG_SEQ = 8'h9c;
  localparam logic [7:0] KC_SYNC = 8'hbc;
  localparam logic [7:0] KC_ALIGN = 8'h7c;
  localparam logic [7:0] KC_SKIP = 8'h1c;
  localparam logic [COLW-1:0] IDLE_COL = {4'hf, {4{XG_IDLE}}};
  localparam logic [COLW-1:0] ERR_COL = {4'hf, {4{XG_ERR}}};
  // ---------------------------------------------------------------------------
  // Slip watermarks, idle generator and reset values
  // ---------------------------------------------------------------------------
  localparam int WM_START = 8;
  localparam int WM_HIGH = 12;
  localparam logic [4:0] ALIGN_MIN = 5'h10;
  localparam logic [6:0] LFSR_SEED = 7'h7f;

  typedef enum logic [0:0] {SL_FILL = 1'b0, SL_RUN = 1'b1} xxb_slip_e;

  function automatic logic col_idle(input logic [COLW-1:0] c);
    return c == IDLE_COL;
  endfunction

  // Frame state after one column: opens on lane-0 start, closes on terminate
  function automatic logic frm_next(input logic f, input logic [COLW-1:0] c);
    logic n;
    n = f;
    if (c[32] && c[7:0] == XG_START) n = 1'b1;
    for (int l = 0; l < LANES; l++) begin
      if (c[32+l] && c[8*l+:8] == XG_TERM) n = 1'b0;
    end
    return n;
  endfunction

  // Returns {ctrl, octet} for a received code group
  function automatic logic [8:0] dec_sym(input logic [7:0] b, input logic k, input int lane);
    logic [8:0] r;
    r = {1'b1, XG_ERR};
    if (!k) r = {1'b0, b};
    else if (b == KC_SYNC || b == KC_ALIGN || b == KC_SKIP) r = {1'b1, XG_IDLE};
    else if (b == XG_TERM || b == XG_ERR) r = {1'b1, b};
    else if ((b == XG_START || b == XG_SEQ) && lane == 0) r = {1'b1, b};
    return r;
  endfunction

  // Returns {k, code group} for one lane of a non-idle column
  function automatic logic [8:0] enc_sym(input logic [7:0] b, input logic c, input int lane);
    logic [8:0] r;
    r = {1'b1, XG_ERR};
    if (!c) r = {1'b0, b};
    else if (b == XG_IDLE) r = {1'b1, KC_SYNC};
    else if (b == XG_TERM || b == XG_ERR) r = {1'b1, b};
    else if ((b == XG_START || b == XG_SEQ) && lane == 0) r = {1'b1, b};
    return r;
  endfunction
endpackage

// *** include/xxb_strm_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface xxb_strm_if #(parameter int W = 72);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

// *** test/xxb_bridge_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module xxb_bridge_tb_top;
  import xxb_pkg::*;
  // --------
  // Lane symbols that stimulus draws from, {flag, octet}
  // --------
  localparam logic [8:0] PICK [10] = '{9'h1fb, 9'h19c, 9'h1fd, 9'h1fe, 9'h1f7, 9'h1bc,
    9'h17c, 9'h11c, 9'h107, 9'h100};
  logic i_ref_clk, i_lnk_clk, i_sys_rst, rx_clk, tx_ovf, rx_ovf;
  logic mon_on = 1'b0, tx_chk = 1'b1, tx_frm = 1'b0, a_dirty = 1'b1;
  logic tx_ovf_seen = 1'b0, rx_ovf_seen = 1'b0;
  logic [35:0] tx_col, c0, c1;
  logic [31:0] rx_data, xrx_data, xtx_data;
  logic [3:0] rx_ctrl, xrx_k, xtx_k;
  logic [35:0] exp_tx[$], exp_rx[$];
  int error_cnt = 0, cmp_count = 0, a_gap = 0, a_cnt = 0, r_cnt = 0, k_cnt = 0;

  xxb_bridge #(.DEPTH(FIFO_DEPTH)) xxb_bridge_inst (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_lnk_clk(i_lnk_clk),
    .i_xgmii_tx_data(tx_col[31:0]), .i_xgmii_tx_ctrl(tx_col[35:32]),
    .o_xgmii_rx_data(rx_data), .o_xgmii_rx_ctrl(rx_ctrl), .o_xgmii_rx_clk(rx_clk),
    .i_xaui_rx_data(xrx_data), .i_xaui_rx_k(xrx_k),
    .o_xaui_tx_data(xtx_data), .o_xaui_tx_k(xtx_k), .o_tx_ovf(tx_ovf), .o_rx_ovf(rx_ovf));
  xxb_serdes_model xxb_serdes_model_inst (.i_lnk_clk(i_lnk_clk), .o_rx_data(xrx_data),
    .o_rx_k(xrx_k), .i_tx_data(xtx_data), .i_tx_k(xtx_k));

  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    i_lnk_clk = 1'b0;
    #7.3;
    forever #15 i_lnk_clk = ~i_lnk_clk;
  end

  // --------
  // Expectation and stimulus helpers
  // --------
  function automatic logic [8:0] xlat(input logic tx, input logic [8:0] s, input int lane);
    if (!s[8]) return s;
    if (!tx && (s[7:0] == KC_SYNC || s[7:0] == KC_ALIGN || s[7:0] == KC_SKIP)) return 9'h107;
    if (tx && s[7:0] == XG_IDLE) return {1'b1, KC_SYNC};
    if (s[7:0] == XG_TERM || s[7:0] == XG_ERR) return s;
    if ((s[7:0] == XG_START || s[7:0] == XG_SEQ) && lane == 0) return s;
    return {1'b1, XG_ERR};
  endfunction
  function automatic logic [35:0] xcol(input logic tx, input logic [35:0] c);
    logic [8:0] s;
    for (int l = 0; l < 4; l++) begin
      s = xlat(tx, {c[32+l], c[8*l+:8]}, l);
      c[32+l] = s[8];
      c[8*l+:8] = s[7:0];
    end
    return c;
  endfunction
  // Flag bit clear in l0 or l3 leaves that lane random
  function automatic logic [35:0] gen(input logic [8:0] l0, input logic [8:0] l3);
    logic [35:0] c;
    logic [8:0] s;
    for (int l = 0; l < 4; l++) begin
      s = ($urandom_range(2) == 0) ? {1'b0, 8'($urandom)} : PICK[$urandom_range(9)];
      if (l == 0 && l0[8]) s = l0;
      if (l == 3 && l3[8]) s = l3;
      c[32+l] = s[8];
      c[8*l+:8] = s[7:0];
    end
    return c;
  endfunction
  task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Falling-edge set value is what the next rising edge samples
  task automatic send(input logic [35:0] a, input logic [35:0] b);
    @(negedge i_ref_clk);
    tx_col <= a;
    @(posedge i_ref_clk);
    tx_col <= b;
  endtask
  task automatic results();
    $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wait_done();
    for (int i = 0; i < 4000 && exp_tx.size() + exp_rx.size() > 0; i++) @(posedge i_ref_clk);
    if (exp_tx.size() + exp_rx.size() > 0) begin
      error_cnt++;
      $display("Error pending columns expected 0 seen %0d", exp_tx.size() + exp_rx.size());
      results();
    end
  endtask
  task automatic rx_take(input logic ph);
    check("rx clock", {35'h0, ph}, {35'h0, rx_clk});
    if ({rx_ctrl, rx_data} !== IDLE_COL) begin
      if (exp_rx.size() == 0) check("rx column", IDLE_COL, {rx_ctrl, rx_data});
      else check("rx column", exp_rx.pop_front(), {rx_ctrl, rx_data});
    end
  endtask

  // --------
  // Monitors
  // --------
  // Pulse is read settled, away from the edge that launches it
  always @(posedge i_ref_clk) begin
    #1;
    if (tx_ovf === 1'b1) tx_ovf_seen = 1'b1;
    if (mon_on) rx_take(1'b1);
    @(negedge i_ref_clk);
    #1;
    if (mon_on) rx_take(1'b0);
  end
  always @(negedge i_lnk_clk) begin
    logic [35:0] c, e;
    c = {xtx_k, xtx_data};
    a_gap++;
    if (rx_ovf === 1'b1) rx_ovf_seen = 1'b1;
    if (mon_on && c[35:32] === 4'hf && c[31:0] === {4{c[7:0]}}
        && c[7:0] inside {KC_SYNC, KC_ALIGN, KC_SKIP}) begin
      if (tx_frm && tx_chk) check("tx frame gap", e, c);
      if (c[7:0] === KC_ALIGN) begin
        if (a_cnt > 0 && !a_dirty && (a_gap < 16 || a_gap > 32)) begin
          error_cnt++;
          $display("Error align gap expected 16 to 32 seen %0d", a_gap);
        end
        a_cnt++;
        a_gap = 0;
        a_dirty = 1'b0;
      end else if (c[7:0] === KC_SKIP) r_cnt++;
      else k_cnt++;
    end else if (mon_on) begin
      a_dirty = 1'b1;
      if (tx_chk && exp_tx.size() == 0) check("tx column", {4'hf, {4{KC_SYNC}}}, c);
      else if (tx_chk) begin
        e = exp_tx.pop_front();
        check("tx column", e, c);
        if (e[32] && e[7:0] == XG_START) tx_frm = 1'b1;
        for (int l = 0; l < 4; l++) if (e[32+l] && e[8*l+:8] == XG_TERM) tx_frm = 1'b0;
      end
    end
  end

  // --------
  // Main sequence
  // --------
  initial begin
    void'($urandom(32'h48ec08cc));
    i_sys_rst = 1'b1;
    tx_col = IDLE_COL;
    repeat (4) @(posedge i_lnk_clk);
    mon_on = 1'b1;
    repeat (2) @(posedge i_lnk_clk);
    check("rx reset column", IDLE_COL, {rx_ctrl, rx_data});
    check("tx reset column", {4'hf, {4{KC_SYNC}}}, {xtx_k, xtx_data});
    @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    $display("Test reset done");
    // Link-side reset lags by its synchroniser; columns sent earlier would be lost
    repeat (4) @(posedge i_lnk_clk);
    @(posedge i_ref_clk);
    for (int n = 0; n < 40; n++) begin
      c0 = gen((n % 4 == 3) ? 9'h19c : 9'h1fb, 9'h1fd);
      xxb_serdes_model_inst.rx_q.push_back(c0);
      exp_rx.push_back(xcol(1'b0, c0));
    end
    repeat (150) send(IDLE_COL, IDLE_COL);
    for (int n = 0; n < 40; n++) begin
      c0 = gen((n % 4 == 3) ? 9'h19c : 9'h1fb, 9'h0);
      c1 = gen(9'h0, 9'h1fd);
      exp_tx.push_back(xcol(1'b1, c0));
      exp_tx.push_back(xcol(1'b1, c1));
      send(c0, c1);
      if (n != 0) repeat (40) send(IDLE_COL, IDLE_COL);
    end
    wait_done();
    check("tx overflow idle", 36'h0, {35'h0, tx_ovf_seen});
    check("rx overflow idle", 36'h0, {35'h0, rx_ovf_seen});
    $display("Test traffic done");
    tx_chk = 1'b0;
    repeat (8) send(gen(9'h1fb, 9'h0), gen(9'h0, 9'h1fd));
    repeat (4) send(IDLE_COL, IDLE_COL);
    check("tx overflow", 36'h1, {35'h0, tx_ovf_seen});
    check("idle group mix", 36'h7, {33'h0, a_cnt > 0, r_cnt > 0, k_cnt > 0});
    $display("Test overflow done");
    results();
  end
endmodule
`default_nettype wire

// *** test/xxb_serdes_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module xxb_serdes_model
  import xxb_pkg::*;
(
  // Link clock
  input wire logic i_lnk_clk,
  // Deskewed columns toward the bridge
  output logic [31:0] o_rx_data,
  output logic [3:0] o_rx_k,
  // Encoded columns from the bridge
  input wire logic [31:0] i_tx_data,
  input wire logic [3:0] i_tx_k
);
  // Columns queued by the bench, {k flags, code groups}
  logic [35:0] rx_q[$];
  logic [7:0] idl;

  initial begin
    o_rx_data = {4{KC_SYNC}};
    o_rx_k = 4'hf;
  end

  // --------
  // Receive feed
  // --------
  // All four lanes leave already deskewed, so one idle group serves every lane
  always @(posedge i_lnk_clk) begin
    case ($urandom_range(2))
      0: idl = KC_SYNC;
      1: idl = KC_ALIGN;
      default: idl = KC_SKIP;
    endcase
    // Random spacing keeps the bridge's slip logic busy
    if (rx_q.size() > 0 && $urandom_range(1) == 1) begin
      {o_rx_k, o_rx_data} <= rx_q.pop_front();
    end else begin
      o_rx_k <= 4'hf;
      o_rx_data <= {4{idl}};
    end
  end
endmodule
`default_nettype wire
